/* nv_sram_host_consts.vh */
// constants for the nonvolatile sram host controller
`ifndef NV_SRAM_HOST_CONSTS_VH
`define NV_SRAM_HOST_CONSTS_VH
`define CLK_PERIOD_NS 20
`define ADDR_W 15
`define DATA_W 8
`define T_RC_NS 35
`define T_PWE_NS 25
`define T_ACE_NS 35
`define T_PHSB_NS 15
`define T_DHSB_NS 35
`define T_SS_US 100
`define T_STORE_MS 8
`define T_RECALL_US 200
`define T_HRECALL_MS 20
`define CYC_RC ((`T_RC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_PWE ((`T_PWE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_ACE ((`T_ACE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_PHSB ((`T_PHSB_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_DHSB ((`T_DHSB_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_SS ((`T_SS_US * 1000) / `CLK_PERIOD_NS)
`define CYC_STORE ((`T_STORE_MS * 1000000) / `CLK_PERIOD_NS)
`define CYC_RECALL ((`T_RECALL_US * 1000) / `CLK_PERIOD_NS)
`define CYC_HRECALL ((`T_HRECALL_MS * 1000000) / `CLK_PERIOD_NS)
`define CNT_W 20
`define SEQ_LEN 6
`define SEQ_W 3
`define OP_READ 2'h0
`define OP_WRITE 2'h1
`define OP_SOFT 2'h2
`define OP_HWSTORE 2'h3
`endif

/* nv_sram_host.v */
// host controller driving the nonvolatile sram pins
`timescale 1ns/1ps
`include "nv_sram_host_consts.vh"
module nv_sram_host #(
	parameter [`CNT_W-1:0] STORE_CYCLES = `CYC_STORE,
	parameter [`CNT_W-1:0] RECALL_CYCLES = `CYC_RECALL,
	parameter [`CNT_W-1:0] SS_CYCLES = `CYC_SS,
	parameter [`CNT_W-1:0] POWERUP_CYCLES = `CYC_HRECALL
) (
	// clock and reset
	input wire clock,
	input wire rst,
	// user command port
	input wire reqValid,
	output wire reqReady,
	input wire [1:0] reqOp,
	input wire [`ADDR_W-1:0] reqAddr,
	input wire [`DATA_W-1:0] reqData,
	input wire [6*`ADDR_W-1:0] seqAddrs,
	input wire softRecall,
	output reg rspValid,
	output reg [`DATA_W-1:0] rspData,
	// memory pins
	output reg ceN,
	output reg weN,
	output reg oeN,
	output reg [`ADDR_W-1:0] addr,
	input wire [`DATA_W-1:0] dqIn,
	output reg [`DATA_W-1:0] dqOut,
	output reg dqOe,
	// store/busy open-drain pin
	input wire store_busy_n_in,
	output wire store_busy_n_out,
	output reg store_busy_n_oe
);
	// ---------------------------------------------------------------
	// states
	// ---------------------------------------------------------------
	localparam [2:0] S_POWERUP = 3'h0;
	localparam [2:0] S_IDLE = 3'h1;
	localparam [2:0] S_READ = 3'h2;
	localparam [2:0] S_WRITE = 3'h3;
	localparam [2:0] S_GAP = 3'h4;
	localparam [2:0] S_HSB = 3'h5;
	localparam [2:0] S_WAIT = 3'h6;
	localparam [2:0] S_BUSY = 3'h7;

	reg [2:0] state;
	reg [`CNT_W-1:0] cnt;
	reg [1:0] op;
	reg [`SEQ_W-1:0] seqIdx;
	reg [`DATA_W-1:0] wdata;
	reg recallCmd;

	function [`ADDR_W-1:0] seqAddr;
		input [6*`ADDR_W-1:0] table_;
		input [`SEQ_W-1:0] idx;
		begin
			seqAddr = table_[idx*`ADDR_W +: `ADDR_W];
		end
	endfunction

	// pin is only ever pulled low
	assign store_busy_n_out = 1'b0;
	// accept only when idle and device not busy
	assign reqReady = (state == S_IDLE) && store_busy_n_in;

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	always @(posedge clock) begin
		if (rst) begin
			state <= S_POWERUP;
			cnt <= {`CNT_W{1'b0}};
			op <= `OP_READ;
			seqIdx <= {`SEQ_W{1'b0}};
			wdata <= {`DATA_W{1'b0}};
			recallCmd <= 1'b0;
			rspValid <= 1'b0;
			rspData <= {`DATA_W{1'b0}};
			ceN <= 1'b1;
			weN <= 1'b1;
			oeN <= 1'b1;
			addr <= {`ADDR_W{1'b0}};
			dqOut <= {`DATA_W{1'b0}};
			dqOe <= 1'b0;
			store_busy_n_oe <= 1'b0;
		end else begin
			rspValid <= 1'b0;
			case (state)
			S_POWERUP: begin
				// power-up recall window
				if (cnt >= POWERUP_CYCLES - 1'b1) begin
					cnt <= {`CNT_W{1'b0}};
					state <= S_IDLE;
				end else begin
					cnt <= cnt + 1'b1;
				end
			end
			S_IDLE: begin
				if (reqValid && store_busy_n_in) begin
					op <= reqOp;
					wdata <= reqData;
					recallCmd <= softRecall;
					seqIdx <= {`SEQ_W{1'b0}};
					cnt <= {`CNT_W{1'b0}};
					case (reqOp)
					`OP_READ: begin
						addr <= reqAddr;
						ceN <= 1'b0;
						oeN <= 1'b0;
						weN <= 1'b1;
						state <= S_READ;
					end
					`OP_WRITE: begin
						addr <= reqAddr;
						oeN <= 1'b1;
						weN <= 1'b0;
						ceN <= 1'b0;
						dqOut <= reqData;
						dqOe <= 1'b1;
						state <= S_WRITE;
					end
					`OP_SOFT: begin
						addr <= seqAddr(seqAddrs, {`SEQ_W{1'b0}});
						ceN <= 1'b0;
						oeN <= 1'b0;
						weN <= 1'b1;
						state <= S_READ;
					end
					`OP_HWSTORE: begin
						store_busy_n_oe <= 1'b1;
						state <= S_HSB;
					end
					default: state <= S_IDLE;
					endcase
				end
			end
			S_READ: begin
				if (cnt >= `CYC_ACE - 1) begin
					cnt <= {`CNT_W{1'b0}};
					ceN <= 1'b1;
					oeN <= 1'b1;
					state <= S_GAP;
					if (op == `OP_READ) begin
						rspData <= dqIn;
						rspValid <= 1'b1;
					end
				end else begin
					cnt <= cnt + 1'b1;
				end
			end
			S_WRITE: begin
				if (cnt >= `CYC_PWE - 1) begin
					cnt <= {`CNT_W{1'b0}};
					weN <= 1'b1;
					ceN <= 1'b1;
					state <= S_GAP;
					rspValid <= 1'b1;
				end else begin
					cnt <= cnt + 1'b1;
				end
			end
			S_GAP: begin
				// one idle cycle; dq released, cycle time met
				dqOe <= 1'b0;
				cnt <= {`CNT_W{1'b0}};
				if (op == `OP_SOFT) begin
					if (seqIdx == `SEQ_LEN - 1) begin
						// sixth read data dropped
						state <= S_WAIT;
					end else begin
						seqIdx <= seqIdx + 1'b1;
						addr <= seqAddr(seqAddrs, seqIdx + 1'b1);
						ceN <= 1'b0;
						oeN <= 1'b0;
						state <= S_READ;
					end
				end else begin
					state <= S_IDLE;
				end
			end
			S_HSB: begin
				if (cnt >= `CYC_PHSB - 1) begin
					store_busy_n_oe <= 1'b0;
					cnt <= {`CNT_W{1'b0}};
					state <= S_WAIT;
				end else begin
					cnt <= cnt + 1'b1;
				end
			end
			S_WAIT: begin
				// allow device to act, then track busy
				if (cnt >= SS_CYCLES - 1'b1) begin
					cnt <= {`CNT_W{1'b0}};
					state <= S_BUSY;
				end else begin
					cnt <= cnt + 1'b1;
				end
			end
			S_BUSY: begin
				if (store_busy_n_in || (cnt >= ((op == `OP_SOFT &&
				    recallCmd) ? RECALL_CYCLES : STORE_CYCLES))) begin
					cnt <= {`CNT_W{1'b0}};
					rspValid <= 1'b1;
					state <= S_IDLE;
				end else begin
					cnt <= cnt + 1'b1;
				end
			end
			default: state <= S_IDLE;
			endcase
		end
	end
endmodule // nv_sram_host

/* nv_sram_host_asserts.sv */
// pin protocol assertions for the nonvolatile sram host
`timescale 1ns/1ps
module nv_sram_host_asserts (
	// watched ports
	input wire clock,
	input wire rst,
	input wire reqReady,
	input wire ceN,
	input wire weN,
	input wire oeN,
	input wire dqOe,
	input wire store_busy_n_in,
	input wire store_busy_n_oe
);
	// ----
	// checks
	// ----
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	AST_RD_WE: assert property (!oeN |-> weN) else $error("rd we");
	AST_RD_DQ: assert property (!oeN |-> !dqOe) else $error("rd dq");
	AST_ACC_PIN: assert property (!ceN |-> !store_busy_n_oe)
		else $error("acc pin");
	AST_RD_LEN: assert property ($fell(oeN) |-> !ceN ##1 !oeN ##1 oeN)
		else $error("rd len");
	AST_WR_LEN: assert property ($fell(weN) |-> dqOe ##1 !weN ##1 weN)
		else $error("wr len");
	AST_PULSE: assert property ($rose(store_busy_n_oe) |=> !reqReady)
		else $error("pulse");
	AST_BUSY_RDY: assert property (!store_busy_n_in |->
		ceN && weN && oeN && !reqReady) else $error("busy rdy");
	AST_BUSY_ACC: assert property (!store_busy_n_in &&
		$past(!store_busy_n_in) |-> ceN) else $error("busy acc");
	cover property ($rose(store_busy_n_oe));
	cover property (!store_busy_n_in && !store_busy_n_oe);
	cover property ($fell(weN));
endmodule // nv_sram_host_asserts
bind nv_sram_host nv_sram_host_asserts i_nv_sram_host_asserts (.*);

/* nv_sram_dev.sv */
// behavioural model of the nonvolatile sram
`timescale 1ns/1ps
module nv_sram_dev #(
	parameter [5:0] BUSY = 6'h1e,
	parameter [89:0] SEQ = 90'h0
) (
	// pins
	input wire clock,
	input wire ceN,
	input wire weN,
	input wire oeN,
	input wire [14:0] addr,
	input wire [7:0] dqOut,
	input wire hostPull,
	output wire [7:0] dqIn,
	output wire busyN
);
	// ----
	// array and nonvolatile sequencing
	// ----
	reg [7:0] mem [0:32767];
	// power-up recall keeps the device busy from time zero
	reg [5:0] busy = BUSY;
	reg [2:0] seq = 3'h0;
	reg dirty = 1'b0;
	reg lastCe = 1'b1;
	reg lastWe = 1'b1;
	reg lastPull = 1'b0;
	wire idle = busyN;
	wire hit = addr == SEQ[seq*15 +: 15];
	assign busyN = !(hostPull || busy != 6'h00);
	// undriven bus shows the inverse so stale data never matches
	assign dqIn = idle && !ceN && !oeN && weN ? mem[addr] : ~mem[addr];
	always @(posedge clock) begin
		lastCe <= ceN;
		lastWe <= weN;
		lastPull <= hostPull;
		if (busy != 6'h00)
			busy <= busy - 6'h01;
		// a write still lands in the first cycle of a pin store
		if ((idle || (hostPull && !lastPull)) && !ceN && !weN) begin
			mem[addr] <= dqOut;
			dirty <= 1'b1;
			seq <= 3'h0;
		end
		if (hostPull && !lastPull && dirty) begin
			busy <= BUSY;
			dirty <= 1'b0;
		end
		if (idle && ceN && !lastCe && lastWe) begin
			seq <= hit ? seq + 3'h1 : 3'h0;
			if (hit && seq == 3'h5) begin
				busy <= BUSY;
				dirty <= 1'b0;
				seq <= 3'h0;
			end
		end
	end
endmodule // nv_sram_dev

/* nv_sram_host_tb.sv */
// self-checking bench for the nonvolatile sram host
`timescale 1ns/1ps
`include "nv_sram_host_consts.vh"
`define CHK(a, b) begin checked = checked + 1; if ((a) !== (b)) begin \
	errors = errors + 1; \
	$display("CHECK FAILED %0t %h %h", $time, a, b); end end
module nv_sram_host_tb;
	localparam [89:0] SEQ = {15'h0fc0, 15'h303f, 15'h3c1f, 15'h03e0,
		15'h31c7, 15'h0e38};
	localparam [5:0] BUSY = 6'h1e;
	reg clock = 1'b0;
	reg rst = 1'b1;
	reg reqValid = 1'b0;
	reg [1:0] reqOp = 2'h0;
	reg [14:0] reqAddr = 15'h0000;
	reg [7:0] reqData = 8'h00;
	reg softRecall = 1'b0;
	wire reqReady, rspValid, ceN, weN, oeN, dqOe, busyN, pull, pullVal;
	wire [7:0] rspData, dqIn, dqOut;
	wire [14:0] addr;
	integer errors = 0, checked = 0, cyc = 0, n = 0;
	always #10 clock = ~clock;
	nv_sram_host #(.STORE_CYCLES(20'h28), .RECALL_CYCLES(20'h05),
		.SS_CYCLES(20'h0a), .POWERUP_CYCLES(20'h14)) i_nv_sram_host (
		.clock(clock), .rst(rst), .reqValid(reqValid), .reqReady(reqReady),
		.reqOp(reqOp), .reqAddr(reqAddr), .reqData(reqData),
		.seqAddrs(SEQ), .softRecall(softRecall), .rspValid(rspValid),
		.rspData(rspData), .ceN(ceN), .weN(weN), .oeN(oeN), .addr(addr),
		.dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .store_busy_n_in(busyN),
		.store_busy_n_out(pullVal), .store_busy_n_oe(pull));
	nv_sram_dev #(.BUSY(BUSY), .SEQ(SEQ)) i_nv_sram_dev (.clock(clock),
		.ceN(ceN), .weN(weN), .oeN(oeN), .addr(addr), .dqOut(dqOut),
		.hostPull(pull), .dqIn(dqIn), .busyN(busyN));
	// ----
	// requests and scenarios
	// ----
	task req(input [1:0] op, input [14:0] a, input [7:0] d);
		begin
			@(negedge clock);
			while (reqReady !== 1'b1)
				@(negedge clock);
			{reqOp, reqAddr, reqData} = {op, a, d};
			reqValid = 1'b1;
			@(negedge clock);
			reqValid = 1'b0;
			n = 0;
			while (rspValid !== 1'b1 && n < 500) begin
				@(negedge clock);
				n = n + 1;
			end
			`CHK(rspValid, 1'b1)
		end
	endtask
	task t_rw;
		begin
			req(`OP_WRITE, 15'h0123, 8'ha5);
			req(`OP_READ, 15'h0123, 8'h00);
			`CHK(rspData, 8'ha5)
		end
	endtask
	task t_soft;
		begin
			req(`OP_SOFT, 15'h0000, 8'h00);
			`CHK(n > BUSY + 10, 1'b1)
			req(`OP_READ, 15'h0123, 8'h00);
			`CHK(rspData, 8'ha5)
			// recall gives up on its short timeout while still busy
			softRecall = 1'b1;
			req(`OP_SOFT, 15'h0000, 8'h00);
			softRecall = 1'b0;
			`CHK(n < BUSY + 10, 1'b1)
			req(`OP_READ, 15'h0123, 8'h00);
			`CHK(rspData, 8'ha5)
		end
	endtask
	task t_hw;
		begin
			req(`OP_HWSTORE, 15'h0000, 8'h00);
			`CHK(n < 16, 1'b1)
			req(`OP_WRITE, 15'h7fff, 8'h3c);
			req(`OP_HWSTORE, 15'h0000, 8'h00);
			`CHK(n > BUSY - 4, 1'b1)
			req(`OP_READ, 15'h7fff, 8'h00);
			`CHK(rspData, 8'h3c)
		end
	endtask
	task stop_test;
		begin
			$display("errors=%0d checked=%0d", errors, checked);
			if (errors == 0 && checked > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	initial begin
		repeat (6) @(negedge clock);
		rst = 1'b0;
		t_rw;
		t_soft;
		t_hw;
		stop_test;
	end
	always @(posedge clock) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			errors = errors + 1;
			stop_test;
		end
	end
endmodule // nv_sram_host_tb
